// File: inc/ctsc_pkg.sv
// package of constants and types for the camera trigger and status control block
package ctsc_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // led and button timing in milliseconds or seconds, converted to clock cycles
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned PURPLE_HOLD_S = 5;
  localparam int unsigned BUTTON_HOLD_S = 10;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned PURPLE_HOLD_CYC = PURPLE_HOLD_S * MS_PER_S * CYC_PER_MS;
  localparam int unsigned BUTTON_HOLD_CYC = BUTTON_HOLD_S * MS_PER_S * CYC_PER_MS;
  // number of purple blinks after the hold
  localparam logic [1:0] RESTORE_BLINKS = 2'h2;
  // factory network address 192.168.1.101
  localparam logic [31:0] DEFAULT_NET_ADDR = 32'hC0A8_0165;
  localparam int unsigned CNT_W = 32;
  // led colour code: bit2 red, bit1 green, bit0 blue
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_BLUE = 3'h1;
  localparam logic [2:0] LED_GREEN = 3'h2;
  localparam logic [2:0] LED_PURPLE = 3'h5;
  localparam logic [2:0] LED_WHITE = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_BLINK_ON,
    ST_BLINK_OFF,
    ST_SELF_RESET
  } ctsc_restore_e;
endpackage

// File: inc/ctsc_trig_if.sv
// interface carrying the synchronised trigger edge between modules
`timescale 1ns/10ps
interface ctsc_trig_if;
  logic rise;
  modport src (output rise);
  modport dst (input rise);
endinterface

// File: src/ctsc_trig_sync.sv
// trigger input synchroniser and rising-edge detector
`timescale 1ns/10ps
module ctsc_trig_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trig_in,
  ctsc_trig_if.src edge_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } ctsc_sync_s;
  ctsc_sync_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta = trig_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.rise = s_q.sync & ~s_q.prev;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign edge_o.rise = s_q.rise;
endmodule

// File: src/ctsc_top.sv
// top of the camera trigger, exposure and status led control block
`timescale 1ns/10ps
// Notes on behaviour
// - trigger honoured only in slave mode
// - slave mode waits for trigger before acquiring
// - trigger event starts a new acquisition
// - trigger recognised on rising edge
// - exposure output active for whole exposure
// - exposure output low during exposure, else high
// - control output level set by processor
// - usb: green blinking while awaiting enumeration
// - steady white during firmware upgrade
// - ethernet: blue blinking while broadcasting unconnected
// - ethernet: steady blue once connected
// - ethernet: green blinking during driver upgrade
// - restore: purple 5s, two blinks, self reset
// - ethernet: only a 10s button press requests restore
// - restore sets network address to factory default
// - usb variant always acts as peripheral
module ctsc_top #(
  parameter logic [31:0] BLINK_HALF_CYC = 32'(ctsc_pkg::BLINK_HALF_CYC),
  parameter logic [31:0] PURPLE_HOLD_CYC = 32'(ctsc_pkg::PURPLE_HOLD_CYC),
  parameter logic [31:0] BUTTON_HOLD_CYC = 32'(ctsc_pkg::BUTTON_HOLD_CYC)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trig_in,
  input wire logic slave_mode,
  input wire logic free_run,
  output logic acq_start,
  input wire logic exposure_active,
  output logic exposure_n,
  input wire logic proc_ctrl,
  output logic ctrl_out,
  input wire logic eth_variant,
  input wire logic usb_enumerated,
  input wire logic eth_connected,
  input wire logic fw_upgrade,
  input wire logic drv_upgrade,
  input wire logic button_pressed,
  input wire logic [31:0] net_addr_wr,
  input wire logic net_addr_we,
  output logic [31:0] net_addr,
  output logic address_restore,
  output logic self_reset,
  output logic usb_host_en,
  output logic [2:0] led_rgb
);
  typedef struct packed {
    logic acq_start;
    logic wait_trig;
    logic exposure_n;
    logic ctrl_out;
    logic [31:0] blink_cnt;
    logic blink_ph;
    logic [31:0] btn_cnt;
    logic btn_armed;
    ctsc_pkg::ctsc_restore_e rst_st;
    logic [31:0] rst_cnt;
    logic [1:0] blinks;
    logic [31:0] net_addr;
    logic address_restore;
    logic self_reset;
    logic [2:0] led;
  } ctsc_state_s;

  ctsc_state_s s_q, s_d;
  ctsc_trig_if trig_bus ();

  ctsc_trig_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .trig_in(trig_in),
    .edge_o(trig_bus.src)
  );

  always_comb begin
    s_d = s_q;
    s_d.acq_start = 1'b0;
    s_d.address_restore = 1'b0;
    s_d.self_reset = 1'b0;

    // acquisition start: follows free_run in master mode, trigger gated in slave mode
    if (slave_mode) begin
      s_d.wait_trig = 1'b1;
      if (s_q.wait_trig && trig_bus.rise) begin
        s_d.acq_start = 1'b1;
      end
    end else begin
      s_d.wait_trig = 1'b0;
      s_d.acq_start = free_run;
    end

    s_d.exposure_n = ~exposure_active;
    s_d.ctrl_out = proc_ctrl;

    // shared blink time base
    if (s_q.blink_cnt >= BLINK_HALF_CYC - 32'h0000_0001) begin
      s_d.blink_cnt = '0;
      s_d.blink_ph = ~s_q.blink_ph;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 32'h0000_0001;
    end

    // long press detection; a press counts once and must be released
    if (!button_pressed) begin
      s_d.btn_cnt = '0;
      s_d.btn_armed = 1'b1;
    end else if (s_q.btn_armed && s_q.btn_cnt < BUTTON_HOLD_CYC) begin
      s_d.btn_cnt = s_q.btn_cnt + 32'h0000_0001;
    end

    if (net_addr_we) begin
      s_d.net_addr = net_addr_wr;
    end

    case (s_q.rst_st)
      ctsc_pkg::ST_IDLE: begin
        if (eth_variant && s_q.btn_armed && button_pressed && s_q.btn_cnt >= BUTTON_HOLD_CYC) begin
          s_d.btn_armed = 1'b0;
          s_d.net_addr = ctsc_pkg::DEFAULT_NET_ADDR;
          s_d.address_restore = 1'b1;
          s_d.rst_cnt = '0;
          s_d.rst_st = ctsc_pkg::ST_HOLD;
        end
      end
      ctsc_pkg::ST_HOLD: begin
        if (s_q.rst_cnt >= PURPLE_HOLD_CYC - 32'h0000_0001) begin
          s_d.rst_cnt = '0;
          s_d.blinks = '0;
          s_d.rst_st = ctsc_pkg::ST_BLINK_OFF;
        end else begin
          s_d.rst_cnt = s_q.rst_cnt + 32'h0000_0001;
        end
      end
      ctsc_pkg::ST_BLINK_OFF: begin
        if (s_q.rst_cnt >= BLINK_HALF_CYC - 32'h0000_0001) begin
          s_d.rst_cnt = '0;
          if (s_q.blinks == ctsc_pkg::RESTORE_BLINKS) begin
            s_d.rst_st = ctsc_pkg::ST_SELF_RESET;
          end else begin
            s_d.rst_st = ctsc_pkg::ST_BLINK_ON;
          end
        end else begin
          s_d.rst_cnt = s_q.rst_cnt + 32'h0000_0001;
        end
      end
      ctsc_pkg::ST_BLINK_ON: begin
        if (s_q.rst_cnt >= BLINK_HALF_CYC - 32'h0000_0001) begin
          s_d.rst_cnt = '0;
          s_d.blinks = s_q.blinks + 2'h1;
          s_d.rst_st = ctsc_pkg::ST_BLINK_OFF;
        end else begin
          s_d.rst_cnt = s_q.rst_cnt + 32'h0000_0001;
        end
      end
      ctsc_pkg::ST_SELF_RESET: begin
        s_d.self_reset = 1'b1;
        s_d.rst_st = ctsc_pkg::ST_IDLE;
      end
      default: begin
        s_d.rst_st = ctsc_pkg::ST_IDLE;
      end
    endcase

    // led selection in fixed priority
    if (fw_upgrade) begin
      s_d.led = ctsc_pkg::LED_WHITE;
    end else if (s_q.rst_st == ctsc_pkg::ST_HOLD || s_q.rst_st == ctsc_pkg::ST_BLINK_ON) begin
      s_d.led = ctsc_pkg::LED_PURPLE;
    end else if (s_q.rst_st != ctsc_pkg::ST_IDLE) begin
      s_d.led = ctsc_pkg::LED_OFF;
    end else if (eth_variant && button_pressed && s_q.btn_armed && s_q.btn_cnt >= BUTTON_HOLD_CYC) begin
      s_d.led = ctsc_pkg::LED_OFF;
    end else if (eth_variant) begin
      if (drv_upgrade) begin
        s_d.led = s_q.blink_ph ? ctsc_pkg::LED_GREEN : ctsc_pkg::LED_OFF;
      end else if (eth_connected) begin
        s_d.led = ctsc_pkg::LED_BLUE;
      end else begin
        s_d.led = s_q.blink_ph ? ctsc_pkg::LED_BLUE : ctsc_pkg::LED_OFF;
      end
    end else if (!usb_enumerated) begin
      s_d.led = s_q.blink_ph ? ctsc_pkg::LED_GREEN : ctsc_pkg::LED_OFF;
    end else begin
      s_d.led = ctsc_pkg::LED_GREEN;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.exposure_n <= 1'b1;
      s_q.btn_armed <= 1'b1;
      s_q.net_addr <= ctsc_pkg::DEFAULT_NET_ADDR;
      s_q.rst_st <= ctsc_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign acq_start = s_q.acq_start;
  assign exposure_n = s_q.exposure_n;
  assign ctrl_out = s_q.ctrl_out;
  assign net_addr = s_q.net_addr;
  assign address_restore = s_q.address_restore;
  assign self_reset = s_q.self_reset;
  assign usb_host_en = 1'b0;
  assign led_rgb = s_q.led;
endmodule

// File: verif/ctsc_assertions.sv
// assertion checker for the trigger, exposure and status led top
`timescale 1ns/10ps
module ctsc_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trig_in,
  input wire logic slave_mode,
  input wire logic free_run,
  input wire logic acq_start,
  input wire logic exposure_active,
  input wire logic exposure_n,
  input wire logic proc_ctrl,
  input wire logic ctrl_out,
  input wire logic fw_upgrade,
  input wire logic [31:0] net_addr,
  input wire logic address_restore,
  input wire logic usb_host_en,
  input wire logic [2:0] led_rgb
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_trig_seen;
    (slave_mode && $rose(trig_in)) ##1 slave_mode [*3];
  endsequence
  sequence s_restore;
    address_restore ##1 !fw_upgrade [*2];
  endsequence
  a_trig_start: assert property (s_trig_seen |=> acq_start)
    else $error("no start");
  a_master_quiet: assert property ((!slave_mode && !free_run) [*5] |-> !acq_start)
    else $error("start in master");
  a_start_needs_trig: assert property ($past(slave_mode) && acq_start |-> $past(trig_in, 4) && !$past(trig_in, 5))
    else $error("start without trigger");
  a_exp_low: assert property (1'b1 |=> exposure_n == !$past(exposure_active))
    else $error("exposure level");
  a_ctrl_copy: assert property ($changed(proc_ctrl) |=> ctrl_out == $past(proc_ctrl))
    else $error("ctrl level");
  a_upgrade_white: assert property (fw_upgrade [*3] |-> led_rgb == ctsc_pkg::LED_WHITE)
    else $error("not white");
  a_usb_peripheral: assert property (!usb_host_en)
    else $error("host on");
  a_restore_addr: assert property (address_restore |-> ##[0:1] net_addr == ctsc_pkg::DEFAULT_NET_ADDR)
    else $error("address kept");
  a_restore_purple: assert property (s_restore |-> led_rgb == ctsc_pkg::LED_PURPLE)
    else $error("not purple");
endmodule
bind ctsc_top ctsc_assertions i_chk (.*);

// File: verif/ctsc_trig_src.sv
// behavioural external trigger source
`timescale 1ns/10ps
module ctsc_trig_src #(
  parameter int PULSE_INTERVAL_CYC = 4000
) (
  input wire logic clk,
  output logic trig_in
);
  initial trig_in = 1'b0;
  // one clean edge, no bounce, held for the start_pulse_interval
  task automatic pulse();
    @(negedge clk);
    trig_in = 1'b1;
    repeat (PULSE_INTERVAL_CYC) @(negedge clk);
    trig_in = 1'b0;
  endtask
endmodule

// File: verif/tb_top.sv
// self-checking testbench of the trigger and status control block
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slave_mode = 1'b0, free_run = 1'b0, exposure_active = 1'b0, proc_ctrl = 1'b0;
  logic eth_variant = 1'b0, usb_enumerated = 1'b0, eth_connected = 1'b0, fw_upgrade = 1'b0;
  logic drv_upgrade = 1'b0, button_pressed = 1'b0, net_addr_we = 1'b0, p;
  logic [31:0] net_addr_wr = 32'h0A00_0002;
  logic trig_in, acq_start, exposure_n, ctrl_out, address_restore, self_reset, usb_host_en;
  logic [31:0] net_addr;
  logic [2:0] led_rgb;
  int failures = 0, check_count = 0;
  always #12.5 clk = ~clk;
  ctsc_trig_src i_src (.clk, .trig_in);
  ctsc_top #(.BLINK_HALF_CYC(32'h0000_0004), .PURPLE_HOLD_CYC(32'h0000_0014),
    .BUTTON_HOLD_CYC(32'h0000_000A)) i_dut (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_trig(input logic m, input logic f, input int n);
    int c;
    c = 0;
    @(negedge clk);
    slave_mode = m;
    free_run = f;
    fork
      i_src.pulse();
      repeat (4100) begin
        @(posedge clk);
        #1 c += (acq_start !== 1'b0);
      end
    join
    @(negedge clk);
    free_run = 1'b0;
    chk("acq_start pulses", n, c);
  endtask
  task automatic t_led(input logic [4:0] st, input logic [2:0] on, input logic bl);
    int a, b;
    a = 0;
    b = 0;
    @(negedge clk);
    {eth_variant, usb_enumerated, eth_connected, fw_upgrade, drv_upgrade} = st;
    exposure_active = bl;
    proc_ctrl = bl;
    repeat (4) @(negedge clk);
    chk("exposure_n", !bl, exposure_n);
    chk("ctrl_out", bl, ctrl_out);
    repeat (20) begin
      @(negedge clk);
      a += (led_rgb === on);
      b += (led_rgb === 3'h0);
    end
    chk("led pattern", {1'b1, bl, 1'b1}, {a > 0, b > 0, a + b == 20});
  endtask
  task automatic t_restore();
    int i, r;
    r = 0;
    p = 1'b1;
    @(negedge clk);
    {eth_variant, fw_upgrade, drv_upgrade, net_addr_we, button_pressed} = 5'b10011;
    repeat (6) @(negedge clk);
    {net_addr_we, button_pressed} = 2'b00;
    repeat (9) @(negedge clk);
    chk("net_addr short press", 32'h0A00_0002, net_addr);
    button_pressed = 1'b1;
    for (i = 0; i < 30 && address_restore !== 1'b1; i++) @(negedge clk);
    if (i == 30) begin
      failures++;
      final_report();
    end
    @(negedge clk);
    button_pressed = 1'b0;
    chk("net_addr restored", ctsc_pkg::DEFAULT_NET_ADDR, net_addr);
    chk("led hold", ctsc_pkg::LED_PURPLE, led_rgb);
    for (i = 0; i < 100 && self_reset !== 1'b1; i++) begin
      @(negedge clk);
      r += (led_rgb === ctsc_pkg::LED_PURPLE && !p);
      p = (led_rgb === ctsc_pkg::LED_PURPLE);
    end
    chk("purple blinks", 2, r);
    chk("self_reset time", 1, i > 36 && i < 46);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_trig(1'b1, 1'b0, 1);
    t_trig(1'b0, 1'b0, 0);
    t_trig(1'b1, 1'b1, 1);
    t_trig(1'b0, 1'b1, 4100);
    t_led(5'b00000, ctsc_pkg::LED_GREEN, 1'b1);
    t_led(5'b01000, ctsc_pkg::LED_GREEN, 1'b0);
    t_led(5'b10000, ctsc_pkg::LED_BLUE, 1'b1);
    t_led(5'b10100, ctsc_pkg::LED_BLUE, 1'b0);
    t_led(5'b10101, ctsc_pkg::LED_GREEN, 1'b1);
    t_led(5'b10111, ctsc_pkg::LED_WHITE, 1'b0);
    chk("usb_host_en", 0, usb_host_en);
    t_restore();
    final_report();
  end
endmodule
